// >>> rtl/ntt_pkg.sv
package ntt_pkg;

   // Table geometry.
   localparam int NTT_ENTRIES   = 8;
   localparam int NTT_IDX_W     = 3;

   // Timing: one second at 100 MHz.
   localparam int NTT_CLK_HZ      = 100000000;
   localparam int NTT_SEC_NS      = 1000000000;
   localparam int NTT_CLK_NS      = 10;
   localparam int NTT_SEC_CYCLES  = NTT_SEC_NS / NTT_CLK_NS;

   // Register byte addresses.
   localparam logic [7:0] NTT_A_CTRL     = 8'h00;
   localparam logic [7:0] NTT_A_TMR_LIFE = 8'h04;
   localparam logic [7:0] NTT_A_ENT_LIFE = 8'h08;
   localparam logic [7:0] NTT_A_TMR_DEF  = 8'h0C;
   localparam logic [7:0] NTT_A_IRQ_STAT = 8'h10;
   localparam logic [7:0] NTT_A_IRQ_MASK = 8'h14;
   localparam logic [7:0] NTT_A_SEL      = 8'h18;
   localparam logic [7:0] NTT_A_W0       = 8'h1C;
   localparam logic [7:0] NTT_A_W1       = 8'h20;
   localparam logic [7:0] NTT_A_W2       = 8'h24;
   localparam logic [7:0] NTT_A_TMR_REM  = 8'h28;
   localparam logic [7:0] NTT_A_ENT_REM  = 8'h2C;
   localparam logic [7:0] NTT_A_PEND     = 8'h30;

   // Interrupt status bits.
   localparam int NTT_IRQ_EXPIRE  = 0;
   localparam int NTT_IRQ_TMREQ   = 1;
   localparam int NTT_IRQ_FULL    = 2;
   localparam int NTT_IRQ_W       = 3;

   // Control bits.
   localparam int NTT_CTRL_WRITE  = 0;
   localparam int NTT_CTRL_DELETE = 1;

   // Reset values.
   localparam logic [31:0] NTT_TMR_LIFE_RST = 32'h0000_0078;
   localparam logic [31:0] NTT_ENT_LIFE_RST = 32'h0000_00B4;
   localparam logic [31:0] NTT_TMR_DEF_RST  = 32'h0000_0000;
   localparam logic [31:0] NTT_UNMAPPED     = 32'h0000_0000;

   // Field layout of one entry.
   typedef struct packed {
      logic        valid;
      logic [15:0] short_addr;
      logic        coherent;
      logic [5:0]  subband_mask;
      logic [1:0]  modulation;
      logic [3:0]  transmit_gain_level;
      logic        gain_step_size;
      logic [23:0] per_band_gain_steps;
      logic [7:0]  link_quality;
      logic [31:0] tone_map_resp_remaining;
      logic [31:0] entry_remaining_life;
   } ntt_entry_t;

   // Parameters carried by a received frame or tone map response.
   typedef struct packed {
      logic [15:0] short_addr;
      logic        coherent;
      logic [5:0]  subband_mask;
      logic [1:0]  modulation;
      logic [3:0]  transmit_gain_level;
      logic        gain_step_size;
      logic [23:0] per_band_gain_steps;
      logic [7:0]  link_quality;
   } ntt_params_t;

   // Lookup answer given to a client.
   typedef struct packed {
      logic        hit;
      logic        tone_map_req_ok;
      ntt_params_t p;
   } ntt_answer_t;

endpackage

// >>> rtl/ntt_neighbour_table.sv
`timescale 1ns/1ns
// Overview of operation
// RQ1: One entry per neighbour in reception range, kept in an eight-entry table.
// RQ2: Any received frame or tone map response updates the matching entry.
// RQ3: Adaptation, MAC and physical layer clients each look up and update the table.
// RQ4: Each entry is keyed by the neighbour's 16-bit short address.
// RQ5: Entry holds one-bit payload scheme, 0 differential, 1 coherent.
// RQ6: Entry holds six-bit sub-band mask, 1 permits a sub-band, 0 forbids.
// RQ7: Entry holds two-bit modulation code, robust up to eight-phase.
// RQ8: Entry holds four-bit transmit gain level used toward that neighbour.
// RQ9: Entry holds gain step size bit, 0 means 6 dB, 1 means 3 dB.
// RQ10: Entry holds six four-bit gain step counts, sub-band 0 in low bits.
// RQ11: Entry holds 32-bit tone map validity seconds, loaded with default on creation.
// RQ12: Tone map request allowed once that counter is zero and data is pending.
// RQ13: Successful tone map response reloads the counter with its configured lifetime.
// RQ14: Entry life counter of 32 bits, reloaded on creation and data or ACK.
// RQ15: Entry whose life reaches zero is invalid and is removed.
// RQ16: Both counters of valid entries decrement each second, stopping at zero.
module ntt_neighbour_table
   import ntt_pkg::*;
#(
   parameter int SEC_CYCLES = NTT_SEC_CYCLES
) (
   // Clock and reset.
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   // Avalon-MM slave.
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // Received frame events from the MAC and physical layer.
   input  wire logic        RX_FRAME,
   input  wire logic        RX_DATA_OR_ACK,
   input  wire logic        RX_TMRESP,
   input  wire ntt_params_t RX_PARAMS,
   // Lookup by the adaptation, MAC and physical layer clients.
   input  wire logic [15:0] ADP_ADDR,
   output ntt_answer_t      ADP_ANS,
   input  wire logic [15:0] MAC_ADDR,
   output ntt_answer_t      MAC_ANS,
   input  wire logic [15:0] PHY_ADDR,
   output ntt_answer_t      PHY_ANS,
   // Interrupt.
   output logic             IRQ
);

   typedef struct packed {
      ntt_entry_t [NTT_ENTRIES-1:0] tab;
      logic [31:0]                  tmr_life;
      logic [31:0]                  ent_life;
      logic [31:0]                  tmr_def;
      logic [NTT_IRQ_W-1:0]         irq_stat;
      logic [NTT_IRQ_W-1:0]         irq_mask;
      logic [NTT_IDX_W-1:0]         sel;
      logic [NTT_ENTRIES-1:0]       pend;
      ntt_params_t                  sw;
      logic [NTT_ENTRIES-1:0]       tmr_req_seen;
      logic [31:0]                  sec_cnt;
      logic                         ack;
      logic [31:0]                  rdata;
      ntt_answer_t                  adp;
      ntt_answer_t                  mac;
      ntt_answer_t                  phy;
   } ntt_state_t;

   ntt_state_t s_r;
   ntt_state_t s_nxt;

   // Finds the slot holding an address; hit flag in the top bit.
   function automatic logic [NTT_IDX_W:0] find(input ntt_state_t s, input logic [15:0] a);
      logic [NTT_IDX_W:0] r;
      r = '0;
      for (int i = 0; i < NTT_ENTRIES; i++) begin
         if (s.tab[i].valid && s.tab[i].short_addr == a && !r[NTT_IDX_W]) begin //RQ4
            r = {1'b1, NTT_IDX_W'(i)};
         end
      end
      return r;
   endfunction

   // Finds a free slot; top bit set when one exists.
   function automatic logic [NTT_IDX_W:0] find_free(input ntt_state_t s);
      logic [NTT_IDX_W:0] r;
      r = '0;
      for (int i = 0; i < NTT_ENTRIES; i++) begin
         if (!s.tab[i].valid && !r[NTT_IDX_W]) begin
            r = {1'b1, NTT_IDX_W'(i)};
         end
      end
      return r;
   endfunction

   function automatic ntt_answer_t answer(input ntt_state_t s, input logic [15:0] a);
      ntt_answer_t        r;
      logic [NTT_IDX_W:0] f;
      f = find(s, a);
      r = '0;
      if (f[NTT_IDX_W]) begin //RQ3
         r.hit = 1'b1;
         r.p   = ntt_params_t'({s.tab[f[NTT_IDX_W-1:0]].short_addr, s.tab[f[NTT_IDX_W-1:0]].coherent,
                  s.tab[f[NTT_IDX_W-1:0]].subband_mask, s.tab[f[NTT_IDX_W-1:0]].modulation,
                  s.tab[f[NTT_IDX_W-1:0]].transmit_gain_level, s.tab[f[NTT_IDX_W-1:0]].gain_step_size,
                  s.tab[f[NTT_IDX_W-1:0]].per_band_gain_steps, s.tab[f[NTT_IDX_W-1:0]].link_quality});
         r.tone_map_req_ok = s.tab[f[NTT_IDX_W-1:0]].tone_map_resp_remaining == 32'h0000_0000
                             && s.pend[f[NTT_IDX_W-1:0]]; //RQ12
      end
      return r;
   endfunction

   function automatic logic [31:0] dec_sat(input logic [31:0] v);
      return (v == 32'h0000_0000) ? v : v - 32'h0000_0001; //RQ16
   endfunction

   // Writes parameters into a slot, creating it when it is new and a slot is free.
   function automatic ntt_state_t upsert(input ntt_state_t s, input ntt_params_t p,
                                         input logic life_reload, input logic tmr_reload);
      ntt_state_t         r;
      logic [NTT_IDX_W:0] f;
      logic [NTT_IDX_W:0] fr;
      logic [NTT_IDX_W-1:0] k;
      logic               fresh;
      r     = s;
      f     = find(s, p.short_addr);
      fr    = find_free(s);
      fresh = !f[NTT_IDX_W];
      k     = f[NTT_IDX_W] ? f[NTT_IDX_W-1:0] : fr[NTT_IDX_W-1:0];
      if (fresh && !fr[NTT_IDX_W]) begin
         r.irq_stat[NTT_IRQ_FULL] = 1'b1;
      end else begin //RQ1
         r.tab[k].valid               = 1'b1;
         r.tab[k].short_addr          = p.short_addr; //RQ4
         r.tab[k].coherent            = p.coherent; //RQ5
         r.tab[k].subband_mask        = p.subband_mask; //RQ6
         r.tab[k].modulation          = p.modulation; //RQ7
         r.tab[k].transmit_gain_level = p.transmit_gain_level; //RQ8
         r.tab[k].gain_step_size      = p.gain_step_size; //RQ9
         r.tab[k].per_band_gain_steps = p.per_band_gain_steps; //RQ10
         r.tab[k].link_quality        = p.link_quality;
         if (fresh) begin
            r.tab[k].tone_map_resp_remaining = s.tmr_def; //RQ11
            r.pend[k]                        = 1'b0;
            r.tmr_req_seen[k]                = 1'b0;
         end
         if (fresh || life_reload) begin
            r.tab[k].entry_remaining_life = s.ent_life; //RQ14
         end
         if (tmr_reload) begin
            r.tab[k].tone_map_resp_remaining = s.tmr_life; //RQ13
            r.tmr_req_seen[k]                = 1'b0;
         end
      end
      return r;
   endfunction

   logic        acc;
   always_comb begin
      ntt_entry_t e;
      s_nxt = s_r;
      e     = s_r.tab[s_r.sel];
      acc   = (AVS_READ || AVS_WRITE) && !s_r.ack;
      s_nxt.ack = acc;

      // Status clear is applied before any event below, so an event in the same cycle wins.
      if (acc && AVS_WRITE && AVS_ADDRESS == NTT_A_IRQ_STAT) begin
         s_nxt.irq_stat = s_r.irq_stat & ~AVS_WRITEDATA[NTT_IRQ_W-1:0];
      end

      // Once-per-second countdown; an entry that runs out is dropped.
      if (s_r.sec_cnt >= 32'(SEC_CYCLES - 1)) begin
         s_nxt.sec_cnt = 32'h0000_0000;
         for (int i = 0; i < NTT_ENTRIES; i++) begin
            if (s_r.tab[i].valid) begin
               s_nxt.tab[i].tone_map_resp_remaining = dec_sat(s_r.tab[i].tone_map_resp_remaining); //RQ16
               s_nxt.tab[i].entry_remaining_life    = dec_sat(s_r.tab[i].entry_remaining_life); //RQ16
               if (s_r.tab[i].entry_remaining_life <= 32'h0000_0001) begin
                  s_nxt.tab[i].valid = 1'b0; //RQ15
                  s_nxt.irq_stat[NTT_IRQ_EXPIRE] = 1'b1;
               end
            end
         end
      end else begin
         s_nxt.sec_cnt = s_r.sec_cnt + 32'h0000_0001;
      end

      // Tone map request becoming permitted raises an event once.
      for (int i = 0; i < NTT_ENTRIES; i++) begin
         if (s_r.tab[i].valid && s_r.pend[i] && s_r.tab[i].tone_map_resp_remaining == 32'h0000_0000
             && !s_r.tmr_req_seen[i]) begin //RQ12
            s_nxt.tmr_req_seen[i]         = 1'b1;
            s_nxt.irq_stat[NTT_IRQ_TMREQ] = 1'b1;
         end
      end

      // Software access.
      if (acc && AVS_WRITE) begin
         unique case (AVS_ADDRESS)
            NTT_A_CTRL: begin
               if (AVS_WRITEDATA[NTT_CTRL_WRITE]) begin
                  s_nxt = upsert(s_nxt, s_r.sw, 1'b1, 1'b0); //RQ3
               end
               if (AVS_WRITEDATA[NTT_CTRL_DELETE]) begin
                  s_nxt.tab[s_r.sel].valid = 1'b0;
               end
            end
            NTT_A_TMR_LIFE: s_nxt.tmr_life = AVS_WRITEDATA;
            NTT_A_ENT_LIFE: s_nxt.ent_life = AVS_WRITEDATA;
            NTT_A_TMR_DEF:  s_nxt.tmr_def  = AVS_WRITEDATA;
            NTT_A_IRQ_STAT: ;
            NTT_A_IRQ_MASK: s_nxt.irq_mask = AVS_WRITEDATA[NTT_IRQ_W-1:0];
            NTT_A_SEL:      s_nxt.sel      = AVS_WRITEDATA[NTT_IDX_W-1:0];
            NTT_A_W0:       {s_nxt.sw.short_addr, s_nxt.sw.link_quality} = AVS_WRITEDATA[23:0];
            NTT_A_W1: begin
               s_nxt.sw.coherent            = AVS_WRITEDATA[0];
               s_nxt.sw.subband_mask        = AVS_WRITEDATA[6:1];
               s_nxt.sw.modulation          = AVS_WRITEDATA[8:7];
               s_nxt.sw.transmit_gain_level = AVS_WRITEDATA[12:9];
               s_nxt.sw.gain_step_size      = AVS_WRITEDATA[13];
            end
            NTT_A_W2:       s_nxt.sw.per_band_gain_steps = AVS_WRITEDATA[23:0];
            NTT_A_PEND:     s_nxt.pend = AVS_WRITEDATA[NTT_ENTRIES-1:0];
            default: ;
         endcase
      end

      // Received frames and tone map responses update the table.
      if (RX_FRAME) begin //RQ2
         s_nxt = upsert(s_nxt, RX_PARAMS, RX_DATA_OR_ACK, RX_TMRESP); //RQ14
      end

      s_nxt.rdata = NTT_UNMAPPED;
      if (acc && AVS_READ) begin
         unique case (AVS_ADDRESS)
            NTT_A_CTRL:     s_nxt.rdata = 32'h0000_0000;
            NTT_A_TMR_LIFE: s_nxt.rdata = s_r.tmr_life;
            NTT_A_ENT_LIFE: s_nxt.rdata = s_r.ent_life;
            NTT_A_TMR_DEF:  s_nxt.rdata = s_r.tmr_def;
            NTT_A_IRQ_STAT: s_nxt.rdata = 32'(s_r.irq_stat);
            NTT_A_IRQ_MASK: s_nxt.rdata = 32'(s_r.irq_mask);
            NTT_A_SEL:      s_nxt.rdata = {e.valid, 28'h0000000, s_r.sel};
            NTT_A_W0:       s_nxt.rdata = {8'h00, e.short_addr, e.link_quality};
            NTT_A_W1:       s_nxt.rdata = {18'h00000, e.gain_step_size, e.transmit_gain_level,
                                           e.modulation, e.subband_mask, e.coherent};
            NTT_A_W2:       s_nxt.rdata = {8'h00, e.per_band_gain_steps};
            NTT_A_TMR_REM:  s_nxt.rdata = e.tone_map_resp_remaining;
            NTT_A_ENT_REM:  s_nxt.rdata = e.entry_remaining_life;
            NTT_A_PEND:     s_nxt.rdata = 32'(s_r.pend);
            default:        s_nxt.rdata = NTT_UNMAPPED;
         endcase
      end

      // Registered answers cost a cycle of latency but keep the search off the client path.
      s_nxt.adp = answer(s_r, ADP_ADDR); //RQ3
      s_nxt.mac = answer(s_r, MAC_ADDR); //RQ3
      s_nxt.phy = answer(s_r, PHY_ADDR); //RQ3
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r          <= '0;
         s_r.tmr_life <= NTT_TMR_LIFE_RST;
         s_r.ent_life <= NTT_ENT_LIFE_RST;
         s_r.tmr_def  <= NTT_TMR_DEF_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_r.ack;
   assign AVS_READDATA    = s_r.rdata;
   assign ADP_ANS         = s_r.adp;
   assign MAC_ANS         = s_r.mac;
   assign PHY_ANS         = s_r.phy;
   assign IRQ             = |(s_r.irq_stat & s_r.irq_mask);

endmodule

// >>> test/ntt_rx_model.sv
`timescale 1ns/1ns
module ntt_rx_model
   import ntt_pkg::*;
(
   // Clock.
   input wire logic    mclk,
   // Frame events toward the table.
   output logic        rx_frame,
   output logic        rx_data_or_ack,
   output logic        rx_tmresp,
   output ntt_params_t rx_params
);
   initial begin
      rx_frame = 1'b0;
      rx_data_or_ack = 1'b0;
      rx_tmresp = 1'b0;
      rx_params = '0;
   end
   // Fields are inverted after the pulse, so nothing can lean on them lingering.
   task automatic send(input ntt_params_t p, input logic d, input logic t);
      @(posedge mclk);
      rx_params <= p;
      rx_data_or_ack <= d;
      rx_tmresp <= t;
      rx_frame <= 1'b1;
      @(posedge mclk);
      rx_frame <= 1'b0;
      rx_data_or_ack <= 1'b0;
      rx_tmresp <= 1'b0;
      rx_params <= ~p;
   endtask
endmodule

// >>> test/ntt_chk_assertions.sv
`timescale 1ns/1ns
module ntt_chk
   import ntt_pkg::*;
#(
   parameter int SEC_CYCLES = NTT_SEC_CYCLES
) (
   // Clock and reset.
   input wire logic        MCLK,
   input wire logic        RST_B,
   // Register bus.
   input wire logic [7:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   // Frames, lookups and interrupt.
   input wire logic        RX_FRAME,
   input wire logic        RX_DATA_OR_ACK,
   input wire logic        RX_TMRESP,
   input wire ntt_params_t RX_PARAMS,
   input wire logic [15:0] ADP_ADDR,
   input wire ntt_answer_t ADP_ANS,
   input wire logic [15:0] MAC_ADDR,
   input wire ntt_answer_t MAC_ANS,
   input wire logic [15:0] PHY_ADDR,
   input wire ntt_answer_t PHY_ANS,
   input wire logic        IRQ
);
   ntt_params_t last_p_r;
   // The fields of a frame are not held after its pulse, so they are kept here.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         last_p_r <= '0;
      end else if (RX_FRAME) begin
         last_p_r <= RX_PARAMS;
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   a_wait_second: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("waitrequest held past the second cycle");
   a_wait_idle: assert property (AVS_WAITREQUEST |-> (AVS_READ || AVS_WRITE))
      else $error("waitrequest without a request");
   a_rdata_idle: assert property (!(AVS_READ && !AVS_WAITREQUEST) |-> AVS_READDATA == 32'h0)
      else $error("read data outside the accept cycle");
   a_adp_key: assert property (ADP_ANS.hit |-> ADP_ANS.p.short_addr == $past(ADP_ADDR))
      else $error("adaptation hit on another address");
   a_mac_key: assert property (MAC_ANS.hit |-> MAC_ANS.p.short_addr == $past(MAC_ADDR))
      else $error("MAC hit on another address");
   a_phy_key: assert property (PHY_ANS.hit |-> PHY_ANS.p.short_addr == $past(PHY_ADDR))
      else $error("PHY hit on another address");
   a_rx_update: assert property (RX_FRAME && MAC_ADDR == RX_PARAMS.short_addr
      |-> ##[2:3] (MAC_ANS.hit && MAC_ANS.p == last_p_r))
      else $error("frame did not update the entry");
   a_tmreq_hit: assert property (MAC_ANS.tone_map_req_ok |-> MAC_ANS.hit)
      else $error("tone map request on a missing entry");
   a_client_agree: assert property (ADP_ADDR == MAC_ADDR |=> ADP_ANS == MAC_ANS)
      else $error("clients disagree on one address");
   c_tmresp: cover property (RX_FRAME && RX_TMRESP);
   c_req_ok: cover property (MAC_ANS.tone_map_req_ok);
   c_irq: cover property ($rose(IRQ));
endmodule
bind ntt_neighbour_table ntt_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.MCLK(MCLK), .RST_B(RST_B),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_FRAME(RX_FRAME),
   .RX_DATA_OR_ACK(RX_DATA_OR_ACK), .RX_TMRESP(RX_TMRESP), .RX_PARAMS(RX_PARAMS), .ADP_ADDR(ADP_ADDR),
   .ADP_ANS(ADP_ANS), .MAC_ADDR(MAC_ADDR), .MAC_ANS(MAC_ANS), .PHY_ADDR(PHY_ADDR), .PHY_ANS(PHY_ANS), .IRQ(IRQ));

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import ntt_pkg::*;
   localparam int SEC = 200;
   logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest, irq;
   logic        rx_frame, rx_data_or_ack, rx_tmresp;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] adp_addr, mac_addr, phy_addr;
   ntt_params_t rx_params, pa, pb;
   ntt_answer_t adp_ans, mac_ans, phy_ans;
   int          n_errors, samples_checked, cycles, slot;
   ntt_neighbour_table #(.SEC_CYCLES(SEC)) DUT (.MCLK(mclk), .RST_B(rst_b), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .RX_FRAME(rx_frame), .RX_DATA_OR_ACK(rx_data_or_ack),
      .RX_TMRESP(rx_tmresp), .RX_PARAMS(rx_params), .ADP_ADDR(adp_addr), .ADP_ANS(adp_ans),
      .MAC_ADDR(mac_addr), .MAC_ANS(mac_ans), .PHY_ADDR(phy_addr), .PHY_ANS(phy_ans), .IRQ(irq));
   ntt_rx_model u_rx (.mclk(mclk), .rx_frame(rx_frame), .rx_data_or_ack(rx_data_or_ack),
      .rx_tmresp(rx_tmresp), .rx_params(rx_params));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task print_verdict;
      $display("compared=%0d mismatches=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict;
      end
   end
   task cmp_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // A second tick may land between the event and the read, so one less is also right.
   task cmp_near(input logic [31:0] got, input logic [31:0] exp);
      cmp_val((got === exp - 32'h1) ? exp : got, exp);
   endtask
   task cmp_par(input ntt_params_t got, input ntt_params_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task av_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      avs_write <= 1'b0;
   endtask
   task av_rd(input logic [7:0] a);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      rd = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task look(input logic [15:0] a);
      @(posedge mclk);
      adp_addr <= a;
      mac_addr <= a;
      phy_addr <= a;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask
   task settle;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask
   task t_reset;
      cmp_val({31'h0, irq}, 32'h0);
      av_rd(NTT_A_TMR_LIFE); cmp_val(rd, 32'h78);
      av_rd(NTT_A_ENT_LIFE); cmp_val(rd, 32'hB4);
      av_rd(NTT_A_TMR_DEF); cmp_val(rd, 32'h0);
      av_rd(NTT_A_IRQ_MASK); cmp_val(rd, 32'h0);
      av_wr(8'h3C, 32'hFFFFFFFF);
      av_rd(8'h3C); cmp_val(rd, 32'h0);
      $display("t_reset done");
   endtask
   task t_create;
      pa = '{16'h1234, 1'b1, 6'h2D, 2'h3, 4'hA, 1'b1, 24'h5A3C96, 8'h7E};
      av_wr(NTT_A_TMR_DEF, 32'h2);
      look(pa.short_addr); cmp_val({31'h0, mac_ans.hit}, 32'h0);
      u_rx.send(pa, 1'b1, 1'b0);
      look(pa.short_addr);
      cmp_par(adp_ans.p, pa);
      cmp_par(mac_ans.p, pa);
      cmp_par(phy_ans.p, pa);
      cmp_val({29'h0, adp_ans.hit, mac_ans.hit, phy_ans.hit}, 32'h7);
      for (int i = 0; i < NTT_ENTRIES; i++) begin
         av_wr(NTT_A_SEL, i);
         av_rd(NTT_A_SEL);
         if (rd[31] === 1'b1) slot = i;
      end
      av_wr(NTT_A_SEL, slot);
      av_rd(NTT_A_ENT_REM); cmp_near(rd, 32'hB4);
      av_rd(NTT_A_TMR_REM); cmp_near(rd, 32'h2);
      $display("t_create done");
   endtask
   task t_tone;
      repeat (3 * SEC) @(posedge mclk);
      av_rd(NTT_A_TMR_REM); cmp_val(rd, 32'h0);
      cmp_val({31'h0, mac_ans.tone_map_req_ok}, 32'h0);
      av_wr(NTT_A_PEND, 32'h1 << slot);
      look(pa.short_addr); cmp_val({31'h0, mac_ans.tone_map_req_ok}, 32'h1);
      av_rd(NTT_A_IRQ_STAT); cmp_val(rd & 32'h2, 32'h2);
      u_rx.send(pa, 1'b0, 1'b1);
      look(pa.short_addr); cmp_val({31'h0, mac_ans.tone_map_req_ok}, 32'h0);
      av_rd(NTT_A_TMR_REM); cmp_near(rd, 32'h78);
      u_rx.send(pa, 1'b1, 1'b0);
      av_rd(NTT_A_ENT_REM); cmp_near(rd, 32'hB4);
      $display("t_tone done");
   endtask
   task t_expire;
      pb = pa;
      pb.short_addr = 16'h0BEE;
      pb.link_quality = 8'h11;
      av_wr(NTT_A_ENT_LIFE, 32'h3);
      av_wr(NTT_A_IRQ_STAT, 32'h7);
      look(pb.short_addr);
      u_rx.send(pb, 1'b1, 1'b0);
      look(pb.short_addr); cmp_val({31'h0, mac_ans.hit}, 32'h1);
      repeat (5 * SEC) @(posedge mclk);
      look(pb.short_addr); cmp_val({31'h0, mac_ans.hit}, 32'h0);
      cmp_val({31'h0, irq}, 32'h0);
      av_rd(NTT_A_IRQ_STAT); cmp_val(rd & 32'h1, 32'h1);
      av_wr(NTT_A_IRQ_MASK, 32'h1);
      settle; cmp_val({31'h0, irq}, 32'h1);
      av_wr(NTT_A_IRQ_STAT, 32'h1);
      settle; cmp_val({31'h0, irq}, 32'h0);
      $display("t_expire done");
   endtask
   task t_soft;
      pb = '{16'h0C0D, 1'b0, 6'h15, 2'h1, 4'h5, 1'b0, 24'h123456, 8'h42};
      av_wr(NTT_A_W0, 32'h000C0D42);
      av_wr(NTT_A_W1, 32'h00000AAA);
      av_wr(NTT_A_W2, 32'h00123456);
      av_wr(NTT_A_CTRL, 32'h1);
      look(pb.short_addr); cmp_par(mac_ans.p, pb);
      for (int i = 0; i < NTT_ENTRIES; i++) begin
         av_wr(NTT_A_SEL, i);
         av_rd(NTT_A_W0);
         if (rd[23:8] === 16'h0C0D) slot = i;
      end
      av_wr(NTT_A_SEL, slot);
      av_rd(NTT_A_W1); cmp_val(rd, 32'h00000AAA);
      av_wr(NTT_A_CTRL, 32'h2);
      look(pb.short_addr); cmp_val({31'h0, mac_ans.hit}, 32'h0);
      $display("t_soft done");
   endtask
   initial begin
      {n_errors, samples_checked, cycles, slot} = '0;
      {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {adp_addr, mac_addr, phy_addr} = '0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset;
      t_create;
      t_tone;
      t_expire;
      t_soft;
      print_verdict;
   end
endmodule
